// [gpb_gpio_bank.sv]
`include "gpb_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module gpb_gpio_bank
  import gpb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // host I/O port
  input wire gpb_io_req_t io_req,
  output logic [7:0] io_rdata_q,
  output logic io_hit_q,
  // configuration from the host-programmed config space
  input wire logic [15:0] runtime_base,
  input wire gpb_pin_cfg_t pin_cfg,
  input wire logic [31:0] alt_out,
  // pins
  input wire logic [31:0] pin_i,
  output logic [31:0] pin_o_q,
  output logic [31:0] pin_oe_q,
  // events
  output logic wake_event_q,
  output logic mgmt_irq_q
);

  // true when the address falls inside an enabled runtime block
  function automatic logic in_block(input logic [15:0] addr, input logic [15:0] base);
    logic ok;
    ok = (base[15:12] == `GPB_BASE_TOP_NIBBLE) && (base >= `GPB_BASE_MIN);
    in_block = ok && (addr[15:4] == base[15:4]);
  endfunction

  // write-one-to-clear with set winning over clear
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr,
                                     input logic [7:0] set);
    w1c = (cur & ~clr) | set;
  endfunction

  // masks as vectors so each register can take its own byte of them
  localparam logic [31:0] WAKE_M = `GPB_WAKE_MASK;
  localparam logic [31:0] MGMT_M = `GPB_MGMT_MASK;

  // synchronised pins and edge history
  logic [31:0] pin_s; // pin levels on clk_sys
  logic [31:0] lvl_q; // polarity-adjusted level, last cycle
  logic [31:0] lvl_d;
  logic [1:0] arm_q; // clocks since reset, saturates once pins are trusted
  logic [1:0] arm_d;

  // host-visible state
  logic [31:0] data_q; // written output values
  logic [31:0] data_d;
  logic [31:0] wake_sts_q; // sticky wake status per pin
  logic [31:0] wake_sts_d;
  logic [31:0] wake_en_q; // per-pin wake enables
  logic [31:0] wake_en_d;
  logic [31:0] mgmt_sts_q; // sticky management status per pin
  logic [31:0] mgmt_sts_d;
  logic [31:0] mgmt_en_q; // per-pin management enables
  logic [31:0] mgmt_en_d;
  logic gsts_q; // global wake status
  logic gsts_d;
  logic gen_q; // global wake enable
  logic gen_d;

  // output flops
  logic [7:0] io_rdata_d;
  logic io_hit_d;
  logic [31:0] pin_o_d;
  logic [31:0] pin_oe_d;
  logic wake_event_d;
  logic mgmt_irq_d;

  // decode helpers
  logic hit;
  logic [3:0] off;
  logic wr;
  logic rd;
  logic [31:0] edge_set;
  logic [31:0] read_view;
  logic [31:0] drive_val;
  logic [31:0] od_eff;
  logic [31:0] wmask;
  logic [31:0] wvec;

  // pins cross into clk_sys before anything looks at them
  gpb_sync u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in(pin_i),
    .sync_out(pin_s)
  );

  // next-state logic for the whole bank
  always_comb begin
    hit = in_block(io_req.addr, runtime_base);
    off = io_req.addr[3:0];
    wr = hit && io_req.wr;
    rd = hit && io_req.rd;

    // polarity applies to input edges as well as read values
    lvl_d = (pin_s ^ pin_cfg.pol_inv) & `GPB_PIN_MASK;
    // synchroniser and lvl_q hold reset zeros at first, so a pin already high
    // would look like a rise; edges are ignored until both carry real levels,
    // at the cost of missing a true edge in the first cycles after reset
    arm_d = (arm_q == `GPB_ARM_CYCLES) ? arm_q : arm_q + 2'h1;
    // rising edge of the adjusted level is the chosen pin edge
    edge_set = (arm_q == `GPB_ARM_CYCLES) ? (lvl_d & ~lvl_q) : `GPB_RST_VEC;

    // read view: input pins show the sampled level, outputs the stored bit
    read_view = ((pin_cfg.dir_in & lvl_d) | (~pin_cfg.dir_in & data_q))
                & `GPB_PIN_MASK;

    // byte write spread across the 32-bit pin vector
    wvec = {io_req.wdata, io_req.wdata, io_req.wdata, io_req.wdata};
    wmask = 32'h00000000;

    // defaults: hold, except the hit flag, taken from this cycle's strobe
    data_d = data_q;
    wake_en_d = wake_en_q;
    mgmt_en_d = mgmt_en_q;
    gen_d = gen_q;
    io_rdata_d = io_rdata_q;
    io_hit_d = hit && (io_req.wr || io_req.rd);

    // status defaults: hold, plus masked pin edges for the wake and management registers
    wake_sts_d = wake_sts_q | (edge_set & `GPB_WAKE_MASK);
    mgmt_sts_d = mgmt_sts_q | (edge_set & `GPB_MGMT_MASK);
    gsts_d = gsts_q;

    if (wr) begin
      unique case (off)
        `GPB_OFF_GLOBAL_STS: begin
          // only a one clears; a pending enabled source sets it again below
          if (io_req.wdata[`GPB_GLOBAL_BIT]) begin
            gsts_d = 1'b0;
          end
        end
        `GPB_OFF_GLOBAL_EN: begin
          gen_d = io_req.wdata[`GPB_GLOBAL_BIT];
        end
        `GPB_OFF_WAKE_STS_A: begin
          wake_sts_d[7:0] = w1c(wake_sts_q[7:0], io_req.wdata, edge_set[7:0])
                            & WAKE_M[7:0];
        end
        `GPB_OFF_WAKE_STS_B: begin
          wake_sts_d[15:8] = w1c(wake_sts_q[15:8], io_req.wdata, edge_set[15:8])
                             & WAKE_M[15:8];
        end
        `GPB_OFF_WAKE_STS_C: begin
          wake_sts_d[23:16] = w1c(wake_sts_q[23:16], io_req.wdata, edge_set[23:16])
                              & WAKE_M[23:16];
        end
        `GPB_OFF_WAKE_EN_A: begin
          wake_en_d[7:0] = io_req.wdata & WAKE_M[7:0];
        end
        `GPB_OFF_WAKE_EN_B: begin
          wake_en_d[15:8] = io_req.wdata & WAKE_M[15:8];
        end
        `GPB_OFF_WAKE_EN_C: begin
          wake_en_d[23:16] = io_req.wdata & WAKE_M[23:16];
        end
        `GPB_OFF_MGMT_STS_A: begin
          mgmt_sts_d[7:0] = w1c(mgmt_sts_q[7:0], io_req.wdata, edge_set[7:0])
                            & MGMT_M[7:0];
        end
        `GPB_OFF_MGMT_STS_B: begin
          mgmt_sts_d[15:8] = w1c(mgmt_sts_q[15:8], io_req.wdata, edge_set[15:8])
                             & MGMT_M[15:8];
        end
        `GPB_OFF_MGMT_EN_A: begin
          mgmt_en_d[7:0] = io_req.wdata & MGMT_M[7:0];
        end
        `GPB_OFF_MGMT_EN_B: begin
          mgmt_en_d[15:8] = io_req.wdata & MGMT_M[15:8];
        end
        `GPB_OFF_DATA_A: begin
          wmask = 32'h000000FF;
        end
        `GPB_OFF_DATA_B: begin
          wmask = 32'h0000FF00;
        end
        `GPB_OFF_DATA_C: begin
          wmask = 32'h00FF0000;
        end
        `GPB_OFF_DATA_D: begin
          wmask = 32'hFF000000;
        end
        default: begin
          // all 16 offsets are decoded above, so no write reaches here
        end
      endcase
    end

    // only output ports store a write; input ports ignore it
    wmask = wmask & ~pin_cfg.dir_in & `GPB_PIN_MASK;
    data_d = (data_q & ~wmask) | (wvec & wmask);

    // global status is set by any enabled pending wake source, whatever gen says
    if (|(wake_sts_d & wake_en_q)) begin
      gsts_d = 1'b1;
    end

    // read data captured in the access cycle
    if (rd) begin
      unique case (off)
        `GPB_OFF_GLOBAL_STS: io_rdata_d = {7'h00, gsts_q};
        `GPB_OFF_GLOBAL_EN: io_rdata_d = {7'h00, gen_q};
        `GPB_OFF_WAKE_STS_A: io_rdata_d = wake_sts_q[7:0];
        `GPB_OFF_WAKE_STS_B: io_rdata_d = wake_sts_q[15:8];
        `GPB_OFF_WAKE_STS_C: io_rdata_d = wake_sts_q[23:16];
        `GPB_OFF_WAKE_EN_A: io_rdata_d = wake_en_q[7:0];
        `GPB_OFF_WAKE_EN_B: io_rdata_d = wake_en_q[15:8];
        `GPB_OFF_WAKE_EN_C: io_rdata_d = wake_en_q[23:16];
        `GPB_OFF_MGMT_STS_A: io_rdata_d = mgmt_sts_q[7:0];
        `GPB_OFF_MGMT_STS_B: io_rdata_d = mgmt_sts_q[15:8];
        `GPB_OFF_MGMT_EN_A: io_rdata_d = mgmt_en_q[7:0];
        `GPB_OFF_MGMT_EN_B: io_rdata_d = mgmt_en_q[15:8];
        `GPB_OFF_DATA_A: io_rdata_d = read_view[7:0];
        `GPB_OFF_DATA_B: io_rdata_d = read_view[15:8];
        `GPB_OFF_DATA_C: io_rdata_d = read_view[23:16];
        `GPB_OFF_DATA_D: io_rdata_d = read_view[31:24];
        default: io_rdata_d = `GPB_RST_BYTE;
      endcase
    end

    // pin drive: alternate function value or data bit, polarity applied
    drive_val = (pin_cfg.alt_sel & alt_out) | (~pin_cfg.alt_sel & data_d);
    drive_val = drive_val ^ pin_cfg.pol_inv;
    // driver type only selectable where the pad supports it
    od_eff = pin_cfg.drive_od & `GPB_OD_MASK;
    // open drain drives low only, releases for a high
    pin_o_d = drive_val & ~od_eff;
    pin_oe_d = ~pin_cfg.dir_in & (~od_eff | ~drive_val) & `GPB_PIN_MASK;

    // wake needs status, its enable and the global enable
    wake_event_d = gen_d && |(wake_sts_d & wake_en_d);
    // management interrupt straight from status and enable
    mgmt_irq_d = |(mgmt_sts_d & mgmt_en_d);
  end

  // register stage for all state and outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= `GPB_RST_VEC;
      arm_q <= 2'h0;
      data_q <= `GPB_RST_VEC;
      wake_sts_q <= `GPB_RST_VEC;
      wake_en_q <= `GPB_RST_VEC;
      mgmt_sts_q <= `GPB_RST_VEC;
      mgmt_en_q <= `GPB_RST_VEC;
      gsts_q <= 1'b0;
      gen_q <= 1'b0;
      io_rdata_q <= `GPB_RST_BYTE;
      io_hit_q <= 1'b0;
      pin_o_q <= `GPB_RST_VEC;
      pin_oe_q <= `GPB_RST_VEC;
      wake_event_q <= 1'b0;
      mgmt_irq_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      arm_q <= arm_d;
      data_q <= data_d;
      wake_sts_q <= wake_sts_d;
      wake_en_q <= wake_en_d;
      mgmt_sts_q <= mgmt_sts_d;
      mgmt_en_q <= mgmt_en_d;
      gsts_q <= gsts_d;
      gen_q <= gen_d;
      io_rdata_q <= io_rdata_d;
      io_hit_q <= io_hit_d;
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      wake_event_q <= wake_event_d;
      mgmt_irq_q <= mgmt_irq_d;
    end
  end

endmodule

`default_nettype wire

// [gpb_consts.svh]
`ifndef GPB_CONSTS_SVH
`define GPB_CONSTS_SVH

// runtime block offsets (low nibble of the host I/O address)
`define GPB_OFF_GLOBAL_STS 4'h0
`define GPB_OFF_GLOBAL_EN 4'h1
`define GPB_OFF_WAKE_STS_A 4'h2
`define GPB_OFF_WAKE_STS_B 4'h3
`define GPB_OFF_WAKE_STS_C 4'h4
`define GPB_OFF_WAKE_EN_A 4'h5
`define GPB_OFF_WAKE_EN_B 4'h6
`define GPB_OFF_WAKE_EN_C 4'h7
`define GPB_OFF_MGMT_STS_A 4'h8
`define GPB_OFF_MGMT_STS_B 4'h9
`define GPB_OFF_MGMT_EN_A 4'hA
`define GPB_OFF_MGMT_EN_B 4'hB
`define GPB_OFF_DATA_A 4'hC
`define GPB_OFF_DATA_B 4'hD
`define GPB_OFF_DATA_C 4'hE
`define GPB_OFF_DATA_D 4'hF

// runtime block base decode window
`define GPB_BASE_MIN 16'h0100
`define GPB_BASE_TOP_NIBBLE 4'h0

// field positions
`define GPB_GLOBAL_BIT 0

// pin masks, bit index = group * 8 + bit
`define GPB_PIN_MASK 32'hFFFF1FFF
`define GPB_WAKE_MASK 32'h00FF1FFF
`define GPB_MGMT_MASK 32'h000018FF
`define GPB_OD_MASK 32'h000001FC

// reset values
`define GPB_RST_BYTE 8'h00
`define GPB_RST_VEC 32'h00000000

// timing counts: clocks after reset before pin edges are trusted
`define GPB_ARM_CYCLES 2'h3

`endif

// [gpb_pkg.sv]
package gpb_pkg;

  // one host I/O cycle, strobes last one clock
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpb_io_req_t;

  // per-pin configuration, bit index = group * 8 + bit
  typedef struct packed {
    logic [31:0] dir_in;
    logic [31:0] pol_inv;
    logic [31:0] drive_od;
    logic [31:0] alt_sel;
  } gpb_pin_cfg_t;

endpackage

// [gpb_sync.sv]
`timescale 1ns/1ns
`default_nettype none

// two-stage synchroniser for the pin inputs
module gpb_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // data
  input wire logic [31:0] async_in,
  output logic [31:0] sync_out
);

  logic [31:0] meta_q; // first stage, read only by the second stage

  // both stages in one process; only sync_out is visible outside
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 32'h00000000;
      sync_out <= 32'h00000000;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// [gpb_gpio_bank_monitor.sv]
`include "gpb_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module gpb_gpio_bank_monitor
  import gpb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // host port
  input wire gpb_io_req_t io_req,
  input wire logic [7:0] io_rdata_q,
  input wire logic io_hit_q,
  // configuration
  input wire logic [15:0] runtime_base,
  input wire gpb_pin_cfg_t pin_cfg,
  input wire logic [31:0] alt_out,
  // pins and events
  input wire logic [31:0] pin_i,
  input wire logic [31:0] pin_o_q,
  input wire logic [31:0] pin_oe_q,
  input wire logic wake_event_q,
  input wire logic mgmt_irq_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // strobe that lands inside the runtime block
  logic blk;
  assign blk = (io_req.wr | io_req.rd) && runtime_base[15:12] == `GPB_BASE_TOP_NIBBLE
    && runtime_base >= `GPB_BASE_MIN && io_req.addr[15:4] == runtime_base[15:4];
  // written byte of group a shows on plain output pins, polarity applied
  property p_out;
    logic [7:0] w, m, p;
    (io_req.wr && blk && io_req.addr[3:0] == `GPB_OFF_DATA_A, w = io_req.wdata,
      m = ~pin_cfg.dir_in[7:0] & ~pin_cfg.alt_sel[7:0] & ~pin_cfg.drive_od[7:0],
      p = pin_cfg.pol_inv[7:0]) |=> ((pin_o_q[7:0] ^ p ^ w) & m) == 8'h00;
  endproperty
  // pins held still for three edges are read back through the synchroniser
  property p_in;
    logic [7:0] v, d, p;
    ($stable(pin_i) [*3] ##0 (io_req.rd && blk && io_req.addr[3:0] == `GPB_OFF_DATA_C,
      v = pin_i[23:16], d = pin_cfg.dir_in[23:16], p = pin_cfg.pol_inv[23:16]))
      |=> ((io_rdata_q ^ v ^ p) & d) == 8'h00;
  endproperty
  AST_HIT: assert property (blk |=> io_hit_q)
    else $error("decoded access gave no hit");
  AST_MISS: assert property (!blk |=> !io_hit_q)
    else $error("hit without a decoded access");
  AST_RD_HOLD: assert property (!(blk && io_req.rd) |=> $stable(io_rdata_q))
    else $error("read data moved without a read");
  AST_OE_IN: assert property ($stable(pin_cfg.dir_in) |-> (pin_oe_q & pin_cfg.dir_in) == '0)
    else $error("input pin driven");
  AST_OD: assert property ($stable(pin_cfg.drive_od) |->
    (pin_oe_q & pin_o_q & pin_cfg.drive_od & `GPB_OD_MASK) == '0)
    else $error("open drain pin drove high");
  AST_GEN_OFF: assert property (io_req.wr && blk && !io_req.wdata[0] &&
    io_req.addr[3:0] == `GPB_OFF_GLOBAL_EN |=> !wake_event_q)
    else $error("wake event with global enable off");
  AST_OUT: assert property (p_out)
    else $error("output pin does not follow written data");
  AST_IN: assert property (p_in)
    else $error("input read differs from pin level");
  cover property (blk && io_req.wr);
  cover property ($rose(wake_event_q));
  cover property ($rose(mgmt_irq_q));
endmodule

bind gpb_gpio_bank gpb_gpio_bank_monitor u_gpb_gpio_bank_monitor (.clk_sys(clk_sys),
  .arst_n(arst_n), .io_req(io_req), .io_rdata_q(io_rdata_q), .io_hit_q(io_hit_q),
  .runtime_base(runtime_base), .pin_cfg(pin_cfg), .alt_out(alt_out), .pin_i(pin_i),
  .pin_o_q(pin_o_q), .pin_oe_q(pin_oe_q), .wake_event_q(wake_event_q),
  .mgmt_irq_q(mgmt_irq_q));
`default_nettype wire

// [gpb_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none

// board side of the pins
module gpb_pin_model (
  // from the bank
  input wire logic [31:0] pin_o_q,
  input wire logic [31:0] pin_oe_q,
  // board drivers
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  // resolved levels
  output logic [31:0] pin_i
);
  // bank wins where it drives; a released pin takes the board driver's value, or floats up to its board pull-up where ext_en is off
  assign pin_i = (pin_oe_q & pin_o_q) | (~pin_oe_q & ~ext_en) | (~pin_oe_q & ext_en & ext_val);
endmodule
`default_nettype wire

// [gpb_gpio_bank_tb_top.sv]
`include "gpb_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module gpb_gpio_bank_tb_top
  import gpb_pkg::*;
;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  gpb_io_req_t req = '0;
  // group c inputs, one open drain and one alternate pin in group a
  gpb_pin_cfg_t cfg = '{32'h00FF0000, 32'h000F0001, 32'h00000004, 32'h00000080};
  logic [15:0] base = 16'h0120;
  logic [31:0] ext_val = 32'h003C0000;
  logic [31:0] pin_i, pin_o_q, pin_oe_q;
  logic [7:0] io_rdata_q, rdv;
  logic io_hit_q, wake_event_q, mgmt_irq_q;
  int fail_count = 0;
  int cmp_count = 0;

  gpb_gpio_bank u_gpb_gpio_bank (.clk_sys(clk_sys), .arst_n(arst_n), .io_req(req),
    .io_rdata_q(io_rdata_q), .io_hit_q(io_hit_q), .runtime_base(base), .pin_cfg(cfg),
    .alt_out(32'h0000007F), .pin_i(pin_i), .pin_o_q(pin_o_q), .pin_oe_q(pin_oe_q),
    .wake_event_q(wake_event_q), .mgmt_irq_q(mgmt_irq_q));
  gpb_pin_model u_gpb_pin_model (.pin_o_q(pin_o_q), .pin_oe_q(pin_oe_q),
    .ext_en(32'h00FF0000), .ext_val(ext_val), .pin_i(pin_i));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  // one host cycle, strobe one clock wide, answer taken a cycle later
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, input logic h);
    @(negedge clk_sys);
    req = '{a, d, w, !w};
    @(negedge clk_sys);
    req.wr = 1'b0;
    req.rd = 1'b0;
    rdv = io_rdata_q;
    chk1("hit", h, io_hit_q);
  endtask
  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    io(1'b1, base | {12'h000, o}, d, 1'b1);
  endtask
  task automatic rd(input logic [3:0] o, input logic [7:0] e);
    io(1'b0, base | {12'h000, o}, 8'h00, 1'b1);
    chk8("rdata", e, rdv);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    test_done();
  end

  initial begin
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    // outputs: polarity, open drain released high, alternate pin takes its own value
    wr(`GPB_OFF_DATA_A, 8'hA5);
    chk8("pin_o", 8'h20, pin_o_q[7:0] & pin_oe_q[7:0]);
    chk8("pin_oe", 8'hFB, pin_oe_q[7:0]);
    rd(`GPB_OFF_DATA_A, 8'hA5);
    wr(`GPB_OFF_DATA_B, 8'hFF);
    rd(`GPB_OFF_DATA_B, 8'h1F);
    $display("output test done");
    // inputs: inverted read, writes ignored, level follows the pin
    rd(`GPB_OFF_DATA_C, 8'h33);
    wr(`GPB_OFF_DATA_C, 8'hFF);
    rd(`GPB_OFF_DATA_C, 8'h33);
    chk8("pin_oe_c", 8'h00, pin_oe_q[23:16]);
    ext_val[16] = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(`GPB_OFF_DATA_C, 8'h32);
    $display("input test done");
    // wake: falling pin is the active edge under inversion
    wr(`GPB_OFF_WAKE_EN_C, 8'h01);
    wr(`GPB_OFF_GLOBAL_EN, 8'h01);
    wr(`GPB_OFF_WAKE_STS_C, 8'hFF);
    chk1("wake", 1'b0, wake_event_q);
    rd(`GPB_OFF_WAKE_STS_C, 8'h00);
    ext_val[16] = 1'b0;
    repeat (4) @(negedge clk_sys);
    rd(`GPB_OFF_WAKE_STS_C, 8'h01);
    chk1("wake", 1'b1, wake_event_q);
    wr(`GPB_OFF_WAKE_STS_C, 8'h00);
    rd(`GPB_OFF_WAKE_STS_C, 8'h01);
    wr(`GPB_OFF_GLOBAL_EN, 8'h00);
    chk1("wake", 1'b0, wake_event_q);
    rd(`GPB_OFF_GLOBAL_STS, 8'h01);
    wr(`GPB_OFF_WAKE_STS_C, 8'h01);
    rd(`GPB_OFF_WAKE_STS_C, 8'h00);
    wr(`GPB_OFF_GLOBAL_STS, 8'h01);
    rd(`GPB_OFF_GLOBAL_STS, 8'h00);
    $display("wake test done");
    // management interrupt from an output pin looped back by the board
    wr(`GPB_OFF_DATA_A, 8'h00);
    wr(`GPB_OFF_MGMT_STS_A, 8'hFF);
    wr(`GPB_OFF_MGMT_EN_A, 8'h01);
    chk1("irq", 1'b0, mgmt_irq_q);
    wr(`GPB_OFF_DATA_A, 8'h01);
    repeat (4) @(negedge clk_sys);
    chk1("irq", 1'b1, mgmt_irq_q);
    wr(`GPB_OFF_MGMT_STS_A, 8'h01);
    chk1("irq", 1'b0, mgmt_irq_q);
    $display("interrupt test done");
    // group b outputs rose when written high; masks trim the reserved bits
    rd(`GPB_OFF_WAKE_STS_B, 8'h1F);
    rd(`GPB_OFF_MGMT_STS_B, 8'h18);
    wr(`GPB_OFF_WAKE_EN_B, 8'hFF);
    rd(`GPB_OFF_WAKE_EN_B, 8'h1F);
    wr(`GPB_OFF_MGMT_EN_B, 8'hFF);
    rd(`GPB_OFF_MGMT_EN_B, 8'h18);
    chk1("irq", 1'b1, mgmt_irq_q);
    wr(`GPB_OFF_MGMT_STS_B, 8'hFF);
    chk1("irq", 1'b0, mgmt_irq_q);
    rd(`GPB_OFF_MGMT_STS_B, 8'h00);
    wr(`GPB_OFF_DATA_D, 8'h5A);
    chk8("pin_o_d", 8'h5A, pin_o_q[31:24]);
    rd(`GPB_OFF_DATA_D, 8'h5A);
    $display("register test done");
    // accesses outside the block are ignored
    io(1'b1, 16'h112C, 8'hFF, 1'b0);
    base = 16'h0080;
    io(1'b1, 16'h008C, 8'hFF, 1'b0);
    base = 16'h0120;
    rd(`GPB_OFF_DATA_A, 8'h01);
    $display("decode test done");
    test_done();
  end
endmodule
`default_nettype wire
